//--- bench/fdd_adc_model.sv
`timescale 1ns/10ps

// ====
// converter core stand-in, one sample per call
module fdd_adc_model (
    // clock
    input wire logic clk_i,
    // sample stream
    output logic smp_valid_o,
    output fdd_pkg::fdd_smp_t smp_o
);
    // quiet at time zero
    initial begin
        smp_valid_o = 1'b0;
        smp_o = '0;
    end
    // idle data is inverted so a stale word never looks valid
    task automatic put(input logic [2:0] ch, input logic [15:0] d);
        @(posedge clk_i);
        smp_valid_o <= 1'b1;
        smp_o <= '{chan: ch, data: d};
        @(posedge clk_i);
        smp_valid_o <= 1'b0;
        smp_o <= '{chan: ~ch, data: ~d};
    endtask
endmodule // fdd_adc_model

//--- bench/fdd_properties.sv
`timescale 1ns/10ps

// ====
// port-level checks for the filter front end
module fdd_properties #(
    parameter int RES_BITS = 16
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // sample streams
    input wire logic smp_valid_i,
    input wire fdd_pkg::fdd_smp_t smp_i,
    input wire logic out_valid_o,
    input wire fdd_pkg::fdd_out_t out_o
);
    logic wr_take;
    logic xlsb_q, xlsb_d;
    logic [1:0] mode_q, mode_d;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // mirror of the two fields the stream checks depend on
    assign wr_take = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o
        && wb_sel_i[0];
    always_comb begin
        xlsb_d = xlsb_q;
        mode_d = mode_q;
        if (rst_i) begin
            xlsb_d = 1'b0;
            mode_d = 2'h0;
        end else if (wr_take && wb_adr_i[11:2] == 10'h068) begin
            xlsb_d = wb_dat_i[0];
        end else if (wr_take && wb_adr_i[11:2] == 10'h090) begin
            mode_d = wb_dat_i[1:0];
        end
    end
    // registers only
    always_ff @(posedge clk_i) begin
        xlsb_q <= xlsb_d;
        mode_q <= mode_d;
    end

    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_after_take: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_ack_needs_req: assert property (
        !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without a request");
    a_reset_quiet: assert property (disable iff (1'b0)
        rst_i |=> !out_valid_o && !wb_ack_o)
        else $error("outputs active after reset edge");
    a_word_holds: assert property (
        !out_valid_o |-> $stable(out_o))
        else $error("output word changed without strobe");
    a_sign_extend: assert property (
        out_valid_o && !(xlsb_q && RES_BITS == 16)
        |-> out_o.data[17:16] == {2{out_o.data[15]}})
        else $error("extra bits used when not allowed");
    a_single_chain: assert property (
        out_valid_o && mode_q == 2'h0 |-> out_o.chan == 3'h0)
        else $error("single mode word not from chain a");
    a_dual_chains: assert property (
        out_valid_o && mode_q == 2'h1 |-> out_o.chan <= 3'h1)
        else $error("dual mode word from unknown chain");
endmodule // fdd_properties

bind fdd_top fdd_properties #(.RES_BITS(RES_BITS)) u_props (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .smp_valid_i(smp_valid_i), .smp_i(smp_i),
    .out_valid_o(out_valid_o), .out_o(out_o)
);

//--- bench/fdd_top_tb_top.sv
`timescale 1ns/10ps

// ====
// bench top: register tasks, stream scenarios, verdict
module fdd_top_tb_top;
    logic clk_i = 1'b0, rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [11:0] wb_adr_i = 12'h000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
    logic wb_ack_o, smp_valid_i, out_valid_o, v14;
    fdd_pkg::fdd_smp_t smp_i;
    fdd_pkg::fdd_out_t out_o, o14;
    fdd_pkg::fdd_out_t oq[$];
    int tq[$];
    int err_total = 0, n_tests = 0, cnt = 0, t_in = -1;
    logic [17:0] d14;
    logic [9:0] ix[8] = '{10'h002, 10'h068, 10'h079, 10'h07A,
                          10'h07B, 10'h07C, 10'h081, 10'h090};
    logic [7:0] mk[8] = '{8'hFF, 8'h01, 8'h01, 8'hFF,
                          8'h03, 8'hFF, 8'h07, 8'h07};

    always #5 clk_i = ~clk_i;

    // full and reduced resolution variants share every input
    fdd_top #(.RES_BITS(16)) DUT (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .smp_valid_i(smp_valid_i),
        .smp_i(smp_i), .out_valid_o(out_valid_o), .out_o(out_o));
    fdd_top #(.RES_BITS(14)) DUT_14 (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(), .wb_ack_o(), .smp_valid_i(smp_valid_i),
        .smp_i(smp_i), .out_valid_o(v14), .out_o(o14));
    fdd_adc_model src (.clk_i(clk_i), .smp_valid_o(smp_valid_i),
        .smp_o(smp_i));

    // ====
    // verdict and comparison
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // stamps and collects output words; also cuts a hang short
    always @(posedge clk_i) begin
        cnt <= cnt + 1;
        if (smp_valid_i && t_in < 0) t_in = cnt;
        if (out_valid_o) begin
            oq.push_back(out_o);
            tq.push_back(cnt);
        end
        if (v14) d14 = o14.data;
        if (cnt > 20000) begin
            err_total++;
            end_sim;
        end
    end

    // ====
    // classic single cycle; only the bench timeout ends a wait
    task automatic wb(input logic we, input logic [9:0] a, input logic [7:0] d,
                      input logic [3:0] sel, output logic [31:0] r);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {a, 2'b00};
        wb_sel_i <= sel;
        wb_dat_i <= {24'h00_0000, d};
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        wb(1'b1, a, d, 4'hF, rd);
    endtask
    task automatic rchk(input string nm, input logic [9:0] a,
                        input logic [31:0] e);
        wb(1'b0, a, 8'h00, 4'hF, rd);
        check(nm, rd, e);
    endtask

    // n samples alternating (c0,a) and (c1,b), then let the pipe drain
    task automatic run(input int n, input logic [2:0] c0, input logic [2:0] c1,
                       input logic [15:0] a, input logic [15:0] b);
        oq.delete();
        tq.delete();
        t_in = -1;
        for (int i = 0; i < n; i++) src.put(i[0] ? c1 : c0, i[0] ? b : a);
        repeat (150) @(posedge clk_i);
    endtask
    // word count, first latency, last chan and data
    task automatic one(input int n, input int lat, input logic [2:0] ch,
                       input logic [17:0] d);
        check("words", oq.size(), n);
        if (oq.size() > 0) begin
            if (lat >= 0) check("latency", tq[0] - t_in, lat);
            check("chan", oq[oq.size()-1].chan, ch);
            check("data", oq[oq.size()-1].data, d);
        end
    endtask

    // ====
    // scenarios
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (ix[i]) begin
            rchk("reset value", ix[i], 32'h0000_0000);
            wr(ix[i], 8'hFF);
            rchk("field width", ix[i], {24'h00_0000, mk[i]});
            wr(ix[i], 8'h00);
        end
        wr(10'h3FF, 8'hFF);
        rchk("unmapped", 10'h3FF, 32'h0000_0000);
        wb(1'b1, 10'h002, 8'hFF, 4'hE, rd);
        rchk("lane off", 10'h002, 32'h0000_0000);
        wr(10'h091, 8'hFF);
        rchk("status ro", 10'h091, 32'h0000_0000);
        $display("done: register map");
        wr(10'h07A, 8'h80);
        rchk("single no recovery", 10'h091, 32'h0000_0000);
        run(1, 3'h0, 3'h0, 16'h8001, 16'h8001);
        one(1, 11, 3'h0, 18'h3_8001);
        run(1, 3'h1, 3'h1, 16'h1234, 16'h1234);
        one(0, -1, 3'h0, 18'h0_0000);
        wr(10'h07A, 8'h01);
        run(4, 3'h0, 3'h0, 16'h0064, 16'h00C8);
        one(2, -1, 3'h0, 18'h0_0096);
        wr(10'h07A, 8'h7F);
        wr(10'h068, 8'h01);
        run(128, 3'h0, 3'h0, 16'h0064, 16'h00C8);
        one(1, -1, 3'h0, 18'h0_0258);
        check("narrow variant", d14, 18'h0_0096);
        wr(10'h068, 8'h00);
        $display("done: single mode");
        wr(10'h07A, 8'h7F);
        wr(10'h07B, 8'h03);
        rchk("nine stages", 10'h091, 32'h0000_0012);
        wr(10'h002, 8'h99);
        rchk("rate field", 10'h002, 32'h0000_0099);
        run(1024, 3'h0, 3'h0, 16'h0123, 16'h0123);
        one(2, -1, 3'h0, 18'h0_0123);
        $display("done: rate 512");
        wr(10'h090, 8'h01);
        wr(10'h079, 8'h01);
        wr(10'h07A, 8'h7E);
        wr(10'h07C, 8'hFF);
        run(512, 3'h0, 3'h1, 16'h0040, 16'h0040);
        one(2, -1, 3'h1, 18'h0_0040);
        if (oq.size() > 0) begin
            check("chain a first", oq[0].chan, 3'h0);
        end
        $display("done: dual rate 256");
        wr(10'h07A, 8'h00);
        rchk("enable off", 10'h091, 32'h0000_0000);
        wr(10'h07A, 8'h80);
        wr(10'h07B, 8'h00);
        wr(10'h07C, 8'h00);
        wr(10'h081, 8'h04);
        rchk("dual recovery", 10'h091, 32'h0000_0200);
        run(2, 3'h0, 3'h0, 16'h0100, 16'h0300);
        one(2, 70, 3'h0, 18'h0_0100);
        wr(10'h090, 8'h02);
        wr(10'h081, 8'h07);
        rchk("octal recovery", 10'h091, 32'h0000_0200);
        run(2, 3'h3, 3'h3, 16'h0100, 16'h0300);
        one(2, 60, 3'h3, 18'h0_0200);
        $display("done: recovery");
        wr(10'h090, 8'h06);
        wr(10'h081, 8'h00);
        wr(10'h07A, 8'h01);
        oq.delete();
        for (int i = 0; i < 16; i++) src.put(i[2:0], 16'h0010);
        repeat (150) @(posedge clk_i);
        one(1, -1, 3'h0, 18'h0_0010);
        $display("done: summed octal");
        end_sim;
    end
endmodule // fdd_top_tb_top

//--- shared/fdd_pkg.sv
package fdd_pkg;

    // ========================================================
    // channel operating modes
    typedef enum logic [1:0] {
        FDD_SINGLE = 2'b00,
        FDD_DUAL = 2'b01,
        FDD_OCTAL = 2'b10,
        FDD_RSVD = 2'b11
    } fdd_mode_t;

    // ========================================================
    // sample carriers
    typedef struct packed {
        logic [2:0] chan;
        logic [15:0] data;
    } fdd_smp_t;

    typedef struct packed {
        logic [2:0] chan;
        logic [17:0] data;
    } fdd_out_t;

endpackage

//--- shared/fdd_regs.svh
`ifndef FDD_REGS_SVH
`define FDD_REGS_SVH

// ============================================================
// register indices (byte address is four times the index)
`define FDD_IDX_RATE 10'h002
`define FDD_IDX_XLSB 10'h068
`define FDD_IDX_TWOCH 10'h079
`define FDD_IDX_CHA_LO 10'h07A
`define FDD_IDX_CHA_HI 10'h07B
`define FDD_IDX_CHB 10'h07C
`define FDD_IDX_RECSEL 10'h081
`define FDD_IDX_MODE 10'h090
`define FDD_IDX_STAT 10'h091

// ============================================================
// field positions
`define FDD_BIT_XLSB 0
`define FDD_BIT_TWOCH 0
`define FDD_BIT_RECEN 7
`define FDD_BIT_RECSEL 0
`define FDD_BIT_EIGHT 1
`define FDD_BIT_BAND 2
`define FDD_BIT_CW 2

// ============================================================
// reset values
`define FDD_RST_RATE 8'h00
`define FDD_RST_BYTE 8'h00
`define FDD_RST_CHA 9'h000
`define FDD_RST_MODE 3'h0

// ============================================================
// timing and sizes
`define FDD_REC_LATENCY 59
`define FDD_STAGES_A 9
`define FDD_STAGES_B 8
`define FDD_RES_FULL 16

`endif

//--- src/fdd_decim_stage.sv
`timescale 1ns/10ps

module fdd_decim_stage #(
    parameter int W = 20
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    input wire logic en_i,
    // input stream
    input wire logic valid_i,
    input wire logic [W-1:0] data_i,
    // output stream
    output logic valid_o,
    output logic [W-1:0] data_o
);

    logic phase_q, phase_d;
    logic [W-1:0] hold_q, hold_d;
    logic valid_q, valid_d;
    logic [W-1:0] data_q, data_d;
    logic [W:0] sum;

    // ========================================================
    // two-tap halfband, one output per input pair
    always_comb begin
        sum = {hold_q[W-1], hold_q} + {data_i[W-1], data_i};
        phase_d = phase_q;
        hold_d = hold_q;
        valid_d = 1'b0;
        data_d = data_q;
        if (!en_i) begin
            // bypass keeps one register so latency per stage is fixed
            phase_d = 1'b0;
            valid_d = valid_i;
            if (valid_i) begin
                data_d = data_i;
            end
        end else if (valid_i) begin
            phase_d = ~phase_q;
            if (phase_q) begin
                valid_d = 1'b1;
                data_d = sum[W:1];
            end else begin
                hold_d = data_i;
            end
        end
    end

    // state registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_q <= 1'b0;
            hold_q <= '0;
            valid_q <= 1'b0;
            data_q <= '0;
        end else begin
            phase_q <= phase_d;
            hold_q <= hold_d;
            valid_q <= valid_d;
            data_q <= data_d;
        end
    end

    assign valid_o = valid_q;
    assign data_o = data_q;

endmodule // fdd_decim_stage

//--- src/fdd_top.sv
`timescale 1ns/10ps
`include "fdd_regs.svh"

module fdd_top #(
    parameter int RES_BITS = 16
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // samples from converter core
    input wire logic smp_valid_i,
    input wire fdd_pkg::fdd_smp_t smp_i,
    // samples to output formatter
    output logic out_valid_o,
    output fdd_pkg::fdd_out_t out_o
);

    localparam int W = 20;
    localparam int DL = `FDD_REC_LATENCY - 1;

    // ========================================================
    // register file
    logic [7:0] rate_q, rate_d;
    logic xlsb_q, xlsb_d, two_q, two_d, recen_q, recen_d;
    logic [8:0] cha_q, cha_d;
    logic [7:0] chb_q, chb_d;
    logic recsel_q, recsel_d, eight_q, eight_d, band_q, band_d;
    logic [2:0] mode_q, mode_d;
    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic [9:0] idx;
    logic wr;
    logic [31:0] stat;
    logic [3:0] cnt_a, cnt_b;
    logic rec_on;

    assign idx = wb_adr_i[11:2];
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & wb_sel_i[0];

    // decode, one wait state, unmapped reads zero
    always_comb begin
        rate_d = rate_q;
        xlsb_d = xlsb_q;
        two_d = two_q;
        recen_d = recen_q;
        cha_d = cha_q;
        chb_d = chb_q;
        recsel_d = recsel_q;
        eight_d = eight_q;
        band_d = band_q;
        mode_d = mode_q;
        ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
        rdat_d = 32'h0000_0000;
        stat = {22'h00_0000, rec_on, cnt_b, cnt_a, 1'b0};
        if (wr) begin
            case (idx)
                `FDD_IDX_RATE: rate_d = wb_dat_i[7:0];
                `FDD_IDX_XLSB: xlsb_d = wb_dat_i[`FDD_BIT_XLSB];
                `FDD_IDX_TWOCH: two_d = wb_dat_i[`FDD_BIT_TWOCH];
                `FDD_IDX_CHA_LO: begin
                    recen_d = wb_dat_i[`FDD_BIT_RECEN];
                    cha_d[6:0] = wb_dat_i[6:0];
                end
                `FDD_IDX_CHA_HI: cha_d[8:7] = wb_dat_i[1:0];
                `FDD_IDX_CHB: chb_d = wb_dat_i[7:0];
                `FDD_IDX_RECSEL: begin
                    recsel_d = wb_dat_i[`FDD_BIT_RECSEL];
                    eight_d = wb_dat_i[`FDD_BIT_EIGHT];
                    band_d = wb_dat_i[`FDD_BIT_BAND];
                end
                `FDD_IDX_MODE: mode_d = wb_dat_i[2:0];
                default: ;
            endcase
        end
        if (ack_d && !wb_we_i) begin
            case (idx)
                `FDD_IDX_RATE: rdat_d[7:0] = rate_q;
                `FDD_IDX_XLSB: rdat_d[0] = xlsb_q;
                `FDD_IDX_TWOCH: rdat_d[0] = two_q;
                `FDD_IDX_CHA_LO: rdat_d[7:0] = {recen_q, cha_q[6:0]};
                `FDD_IDX_CHA_HI: rdat_d[1:0] = cha_q[8:7];
                `FDD_IDX_CHB: rdat_d[7:0] = chb_q;
                `FDD_IDX_RECSEL: rdat_d[2:0] = {band_q, eight_q, recsel_q};
                `FDD_IDX_MODE: rdat_d[2:0] = mode_q;
                `FDD_IDX_STAT: rdat_d = stat;
                default: rdat_d = 32'h0000_0000;
            endcase
        end
    end

    // register file flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rate_q <= `FDD_RST_RATE;
            xlsb_q <= 1'b0;
            two_q <= 1'b0;
            recen_q <= 1'b0;
            cha_q <= `FDD_RST_CHA;
            chb_q <= `FDD_RST_BYTE;
            recsel_q <= 1'b0;
            eight_q <= 1'b0;
            band_q <= 1'b0;
            mode_q <= `FDD_RST_MODE;
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            rate_q <= rate_d;
            xlsb_q <= xlsb_d;
            two_q <= two_d;
            recen_q <= recen_d;
            cha_q <= cha_d;
            chb_q <= chb_d;
            recsel_q <= recsel_d;
            eight_q <= eight_d;
            band_q <= band_d;
            mode_q <= mode_d;
            ack_q <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // ========================================================
    // mode decode
    fdd_pkg::fdd_mode_t mode;
    logic is_dual, is_octal, is_cw, band_eff;
    assign mode = fdd_pkg::fdd_mode_t'(mode_q[1:0]);
    assign is_dual = (mode == fdd_pkg::FDD_DUAL);
    assign is_octal = (mode == fdd_pkg::FDD_OCTAL);
    assign is_cw = is_octal & mode_q[`FDD_BIT_CW];
    // recovery only with the matching select pattern
    assign rec_on = recen_q & ((is_dual & ~recsel_q & ~eight_q & two_q)
        | (is_octal & recsel_q & eight_q));
    assign band_eff = band_q & is_dual;

    // ========================================================
    // delay recovery: interpolate against last sample of channel
    logic [15:0] prev_q [0:7];
    logic [15:0] prev_d [0:7];
    logic rv_q, rv_d;
    fdd_pkg::fdd_smp_t rs_q, rs_d;
    logic [16:0] isum;

    always_comb begin
        prev_d = prev_q;
        rv_d = smp_valid_i & rec_on;
        rs_d = rs_q;
        if (band_eff) begin
            isum = {smp_i.data[15], smp_i.data}
                - {prev_q[smp_i.chan][15], prev_q[smp_i.chan]};
        end else begin
            isum = {smp_i.data[15], smp_i.data}
                + {prev_q[smp_i.chan][15], prev_q[smp_i.chan]};
        end
        if (smp_valid_i) begin
            prev_d[smp_i.chan] = smp_i.data;
            rs_d.chan = smp_i.chan;
            rs_d.data = isum[16:1];
        end
    end

    // interpolator register, first of the 59
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rv_q <= 1'b0;
            rs_q <= '0;
            for (int i = 0; i < 8; i++) begin
                prev_q[i] <= 16'h0000;
            end
        end else begin
            rv_q <= rv_d;
            rs_q <= rs_d;
            prev_q <= prev_d;
        end
    end

    // remaining latency as a plain shift line
    logic [19:0] dl_q [0:DL-1];
    logic [19:0] dl_d [0:DL-1];
    always_comb begin
        dl_d[0] = {rv_q, rs_q};
        for (int i = 1; i < DL; i++) begin
            dl_d[i] = dl_q[i-1];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < DL; i++) begin
                dl_q[i] <= 20'h0_0000;
            end
        end else begin
            dl_q <= dl_d;
        end
    end

    // recovery first in the chain, ahead of everything else
    logic pv;
    fdd_pkg::fdd_smp_t ps;
    assign pv = rec_on ? dl_q[DL-1][19] : smp_valid_i;
    assign ps = rec_on ? dl_q[DL-1][18:0] : smp_i;

    // ========================================================
    // front end: cw summing and chain steering
    logic [18:0] cw_q, cw_d;
    logic av_q, av_d, bv_q, bv_d;
    logic [W-1:0] ad_q, ad_d, bd_q, bd_d;
    logic [18:0] cw_next;

    always_comb begin
        cw_d = cw_q;
        av_d = 1'b0;
        bv_d = 1'b0;
        ad_d = ad_q;
        bd_d = bd_q;
        cw_next = cw_q + {{3{ps.data[15]}}, ps.data};
        if (pv) begin
            if (is_cw) begin
                // eight channels summed before filtering
                cw_d = (ps.chan == 3'h7) ? 19'h0_0000 : cw_next;
                if (ps.chan == 3'h7) begin
                    av_d = 1'b1;
                    ad_d = {cw_next, 1'b0};
                end
            end else if (is_dual) begin
                av_d = (ps.chan == 3'h0);
                bv_d = (ps.chan == 3'h1);
                ad_d = {ps.data, 4'h0};
                bd_d = {ps.data, 4'h0};
            end else if (mode == fdd_pkg::FDD_SINGLE) begin
                av_d = (ps.chan == 3'h0);
                ad_d = {ps.data, 4'h0};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cw_q <= 19'h0_0000;
            av_q <= 1'b0;
            bv_q <= 1'b0;
            ad_q <= 20'h0_0000;
            bd_q <= 20'h0_0000;
        end else begin
            cw_q <= cw_d;
            av_q <= av_d;
            bv_q <= bv_d;
            ad_q <= ad_d;
            bd_q <= bd_d;
        end
    end

    // ========================================================
    // stage enables from thermometer codes
    logic [8:0] en_a;
    logic [7:0] en_b;
    always_comb begin
        en_a = 9'h000;
        en_b = 8'h00;
        cnt_a = 4'h0;
        cnt_b = 4'h0;
        if (is_dual) begin
            // stage one of chain A idles, capping the rate at 256x
            en_a[1] = cha_q[1];
            en_b[0] = chb_q[0] & cha_q[1];
            for (int k = 2; k < 9; k++) begin
                en_a[k] = en_a[k-1] & cha_q[k] & chb_q[k-1];
            end
            en_a[1] = en_b[0];
            for (int k = 1; k < 8; k++) begin
                en_b[k] = en_a[k+1];
            end
        end else if (!is_octal || is_cw) begin
            en_a[0] = cha_q[0];
            for (int k = 1; k < 9; k++) begin
                en_a[k] = en_a[k-1] & cha_q[k];
            end
        end
        for (int k = 0; k < 9; k++) begin
            cnt_a = cnt_a + {3'h0, en_a[k]};
        end
        for (int k = 0; k < 8; k++) begin
            cnt_b = cnt_b + {3'h0, en_b[k]};
        end
    end

    // ========================================================
    // cascaded chains
    logic [`FDD_STAGES_A:0] va;
    logic [W-1:0] da [0:`FDD_STAGES_A];
    logic [`FDD_STAGES_B:0] vb;
    logic [W-1:0] db [0:`FDD_STAGES_B];
    assign va[0] = av_q;
    assign da[0] = ad_q;
    assign vb[0] = bv_q;
    assign db[0] = bd_q;

    genvar g;
    generate
        for (g = 0; g < `FDD_STAGES_A; g++) begin : g_cha
            fdd_decim_stage #(.W(W)) u_st (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .en_i(en_a[g]),
                .valid_i(va[g]),
                .data_i(da[g]),
                .valid_o(va[g+1]),
                .data_o(da[g+1])
            );
        end
        for (g = 0; g < `FDD_STAGES_B; g++) begin : g_chb
            fdd_decim_stage #(.W(W)) u_st (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .en_i(en_b[g]),
                .valid_i(vb[g]),
                .data_i(db[g]),
                .valid_o(vb[g+1]),
                .data_o(db[g+1])
            );
        end
    endgenerate

    // ========================================================
    // output: chain A first, a clashing B word waits one slot
    logic xlsb_eff;
    logic pend_q, pend_d;
    logic [W-1:0] pdat_q, pdat_d;
    logic ov_q, ov_d;
    fdd_pkg::fdd_out_t oq_q, oq_d;
    assign xlsb_eff = xlsb_q & (RES_BITS == `FDD_RES_FULL);

    function automatic logic [17:0] fmt(input logic [W-1:0] x,
                                        input logic ext);
        fmt = ext ? x[W-1:2] : {{2{x[W-1]}}, x[W-1:4]};
    endfunction

    always_comb begin
        pend_d = pend_q;
        pdat_d = pdat_q;
        ov_d = 1'b0;
        oq_d = oq_q;
        if (is_octal && !is_cw) begin
            // plain octal: no filters, samples pass straight on
            ov_d = pv;
            if (pv) begin
                oq_d.chan = ps.chan;
                oq_d.data = {{2{ps.data[15]}}, ps.data};
            end
            pend_d = 1'b0;
        end else if (va[`FDD_STAGES_A]) begin
            ov_d = 1'b1;
            oq_d.chan = 3'h0;
            oq_d.data = fmt(da[`FDD_STAGES_A], xlsb_eff & (cnt_a != 4'h0));
            if (vb[`FDD_STAGES_B]) begin
                pend_d = 1'b1;
                pdat_d = db[`FDD_STAGES_B];
            end
        end else if (pend_q || vb[`FDD_STAGES_B]) begin
            ov_d = 1'b1;
            oq_d.chan = 3'h1;
            oq_d.data = fmt(pend_q ? pdat_q : db[`FDD_STAGES_B],
                            xlsb_eff & (cnt_b != 4'h0));
            pend_d = pend_q & vb[`FDD_STAGES_B];
            pdat_d = db[`FDD_STAGES_B];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_q <= 1'b0;
            pdat_q <= 20'h0_0000;
            ov_q <= 1'b0;
            oq_q <= '0;
        end else begin
            pend_q <= pend_d;
            pdat_q <= pdat_d;
            ov_q <= ov_d;
            oq_q <= oq_d;
        end
    end

    assign out_valid_o = ov_q;
    assign out_o = oq_q;

endmodule // fdd_top
